// [hw/iwdc_top.sv]
// Independent watchdog counter: a 14-bit down counter on slow ticks.
// Assumes refresh, start and config come from logic on sys_clk_i.
module iwdc_top
(
    // Clock and reset.
    input wire logic sys_clk_i,
    input wire logic reset_i,
    // Slow on-chip oscillator, asynchronous to the system clock.
    input wire logic low_speed_internal_osc_i,
    // Configuration levels.
    input wire logic [1:0] action_sel_i,
    input wire logic auto_start_i,
    // Refresh write strobe with its data byte.
    input wire logic refresh_wr_i,
    input wire logic [7:0] refresh_data_i,
    // Event outputs.
    output logic chip_reset_o,
    output logic nmi_o,
    output logic underflow_irq_o,
    output logic refresh_error_o,
    // Status.
    output logic [13:0] count_o,
    output logic running_o
);
    logic tick; // One-cycle pulse per oscillator rising edge.
    iwdc_pkg::iwdc_state_e state_reg; // Counter state.
    iwdc_pkg::iwdc_state_e state_next; // Next counter state.
    logic [iwdc_pkg::CNT_W-1:0] count_reg; // Down counter.
    logic key_armed_reg; // First refresh byte seen.
    logic refresh_ok; // Complete, valid refresh sequence.
    logic refresh_bad; // Refresh write out of sequence.
    logic underflow; // Counter passes below zero this cycle.
    logic [2:0] rst_cnt_reg; // Remaining reset pulse cycles.
    logic start_event; // Any event that starts counting.
    logic first_cycle_reg; // High in the first cycle after reset.

    // Oscillator ticks enable the counter, which is clocked by the system clock.
    iwdc_tick_sync u_tick
    (
        .sys_clk_i(sys_clk_i),
        .reset_i(reset_i),
        .osc_i(low_speed_internal_osc_i),
        .tick_o(tick)
    );

    // Refresh decoding: first key then second key; any other byte, or a second key not armed by the first, is an error.
    always_comb
    begin
        refresh_ok = 1'b0;
        refresh_bad = 1'b0;
        if (refresh_wr_i)
        begin
            if (refresh_data_i == iwdc_pkg::KEY_FIRST)
            begin
                // A lone first key only arms the pair and is never an error.
                refresh_ok = 1'b0;
            end
            else if (key_armed_reg &&
                     refresh_data_i == iwdc_pkg::KEY_SECOND)
            begin
                refresh_ok = 1'b1;
            end
            else
            begin
                refresh_bad = 1'b1;
            end
        end
    end

    // Key sequence tracker.
    // Any other write disarms it, so the two keys must be adjacent.
    always_ff @(posedge sys_clk_i)
    begin
        if (reset_i)
        begin
            key_armed_reg <= 1'b0;
        end
        else if (refresh_wr_i)
        begin
            key_armed_reg <= (refresh_data_i == iwdc_pkg::KEY_FIRST);
        end
    end

    // First cycle after reset marks the reset start event.
    // It is set during reset so the start lands on the first free edge.
    always_ff @(posedge sys_clk_i)
    begin
        if (reset_i)
        begin
            first_cycle_reg <= 1'b1;
        end
        else
        begin
            first_cycle_reg <= 1'b0;
        end
    end

    // Underflow when a tick arrives with the counter at zero.
    // A reload value of N thus gives N plus one ticks before the action.
    assign underflow = (state_reg == iwdc_pkg::IWDC_RUN) && tick &&
                       (count_reg == '0);

    // Auto start on reset, underflow, refresh error; refresh always starts.
    assign start_event = refresh_ok | (auto_start_i &
        (first_cycle_reg | underflow | refresh_bad));

    // State transitions.
    // A valid refresh wins over an underflow or error in the same cycle.
    always_comb
    begin
        state_next = state_reg;
        case (state_reg)
            iwdc_pkg::IWDC_STOP:
            begin
                if (start_event)
                begin
                    state_next = iwdc_pkg::IWDC_RUN;
                end
            end
            iwdc_pkg::IWDC_RUN:
            begin
                if (refresh_ok)
                begin
                    state_next = iwdc_pkg::IWDC_RUN;
                end
                else if (underflow || refresh_bad)
                begin
                    state_next = auto_start_i ? iwdc_pkg::IWDC_RUN
                                              : iwdc_pkg::IWDC_EXPIRED;
                end
            end
            iwdc_pkg::IWDC_EXPIRED:
            begin
                if (start_event)
                begin
                    state_next = iwdc_pkg::IWDC_RUN;
                end
            end
            default:
            begin
                state_next = iwdc_pkg::IWDC_STOP;
            end
        endcase
    end

    // State register.
    always_ff @(posedge sys_clk_i)
    begin
        if (reset_i)
        begin
            state_reg <= iwdc_pkg::IWDC_STOP;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    // Down counter: reload on start, refresh, underflow or bad refresh, else count on ticks in IWDC_RUN.
    // Reload comes first, so a refresh that meets a tick is never lost.
    always_ff @(posedge sys_clk_i)
    begin
        if (reset_i)
        begin
            count_reg <= iwdc_pkg::CNT_RELOAD;
        end
        else if (start_event || underflow || refresh_bad)
        begin
            count_reg <= iwdc_pkg::CNT_RELOAD;
        end
        else if (state_reg == iwdc_pkg::IWDC_RUN && tick)
        begin
            count_reg <= count_reg - 14'h0001;
        end
    end

    // Reset request pulse, NMI or interrupt on underflow; error flag on bad refresh outside IWDC_STOP.
    // The reset request is stretched so that the reset logic sees it.
    always_ff @(posedge sys_clk_i)
    begin
        if (reset_i)
        begin
            rst_cnt_reg <= 3'h0;
            nmi_o <= 1'b0;
            underflow_irq_o <= 1'b0;
            refresh_error_o <= 1'b0;
        end
        else
        begin
            nmi_o <= 1'b0;
            underflow_irq_o <= 1'b0;
            refresh_error_o <= refresh_bad && state_reg != iwdc_pkg::IWDC_STOP;
            if (underflow)
            begin
                case (action_sel_i)
                    iwdc_pkg::ACT_RESET:
                    begin
                        rst_cnt_reg <= 3'(iwdc_pkg::RST_PULSE_CYC);
                    end
                    iwdc_pkg::ACT_NMI:
                    begin
                        nmi_o <= 1'b1;
                    end
                    default:
                    begin
                        underflow_irq_o <= 1'b1;
                    end
                endcase
            end
            else if (rst_cnt_reg != 3'h0)
            begin
                rst_cnt_reg <= rst_cnt_reg - 3'h1;
            end
        end
    end

    // Status outputs.
    // The reset request stands while the pulse counter is not zero.
    assign chip_reset_o = (rst_cnt_reg != 3'h0);
    assign count_o = count_reg;
    assign running_o = (state_reg == iwdc_pkg::IWDC_RUN);
endmodule

// [hw/iwdc_pkg.sv]
// Package with the constants of the independent watchdog counter.
// Assumes a single system clock at 25 MHz and a slow oscillator pin input.
package iwdc_pkg;
    // Counter width and the reload value after a refresh.
    localparam int CNT_W = 14;
    localparam logic [13:0] CNT_RELOAD = 14'h3FFF;
    // Underflow action selection codes.
    localparam logic [1:0] ACT_RESET = 2'h0;
    localparam logic [1:0] ACT_NMI = 2'h1;
    localparam logic [1:0] ACT_IRQ = 2'h2;
    // Length of the chip reset request pulse in system clock cycles.
    localparam int RST_PULSE_CYC = 4;
    // Refresh key sequence: first byte then second byte.
    localparam logic [7:0] KEY_FIRST = 8'h00;
    localparam logic [7:0] KEY_SECOND = 8'hFF;
    // Counter states, Gray coded along stop, run, expired.
    typedef enum logic [1:0]
    {
        IWDC_STOP = 2'b00,
        IWDC_RUN = 2'b01,
        IWDC_EXPIRED = 2'b11
    } iwdc_state_e;
endpackage

// [hw/iwdc_tick_sync.sv]
// Synchroniser and rising edge detector for the slow oscillator input.
// Assumes the oscillator is much slower than the system clock.
module iwdc_tick_sync
(
    // Clock and reset.
    input wire logic sys_clk_i,
    input wire logic reset_i,
    // Asynchronous oscillator level.
    input wire logic osc_i,
    // One-cycle pulse per oscillator rising edge.
    output logic tick_o
);
    logic meta_reg; // First stage, read by the second stage only.
    logic sync_reg; // Second stage.
    logic last_reg; // Previous synchronised level.

    // Two flip-flop synchroniser followed by an edge register.
    always_ff @(posedge sys_clk_i)
    begin
        if (reset_i)
        begin
            meta_reg <= 1'b0;
            sync_reg <= 1'b0;
            last_reg <= 1'b0;
        end
        else
        begin
            meta_reg <= osc_i;
            sync_reg <= meta_reg;
            last_reg <= sync_reg;
        end
    end

    // A tick marks each rising edge of the synchronised oscillator.
    assign tick_o = sync_reg & ~last_reg;
endmodule

// [tb/iwdc_top_sva.sv]
// Checker for the watchdog counter, watching only the top ports.
// Assumes one clock domain with a synchronous active high reset.
module iwdc_top_sva
(
    // Clock and reset.
    input wire logic sys_clk_i,
    input wire logic reset_i,
    // Configuration and refresh inputs.
    input wire logic [1:0] action_sel_i,
    input wire logic auto_start_i,
    input wire logic refresh_wr_i,
    input wire logic [7:0] refresh_data_i,
    // Events and status.
    input wire logic chip_reset_o,
    input wire logic nmi_o,
    input wire logic underflow_irq_o,
    input wire logic refresh_error_o,
    input wire logic [13:0] count_o,
    input wire logic running_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (reset_i);
    // A key pair reloads the full count and starts the countdown.
    reload_on_key_a: assert property (
        refresh_wr_i && refresh_data_i == 8'h00 ##1 refresh_wr_i
        && refresh_data_i == 8'hFF |=> count_o == 14'h3FFF && running_o)
        else $error("count not reloaded by key pair");
    // The count only steps down by one or reloads.
    count_step_a: assert property (
        $changed(count_o) |->
        count_o == $past(count_o) - 14'h1 || count_o == 14'h3FFF)
        else $error("count moved by other than one");
    // A stopped counter keeps its value.
    stop_hold_a: assert property (
        !running_o && !$past(running_o) |-> $stable(count_o))
        else $error("count moved while stopped");
    // Each action fires only from a zero count with its code selected.
    nmi_cause_a: assert property (
        $rose(nmi_o) |-> $past(action_sel_i) == 2'h1 && $past(count_o) == 0)
        else $error("nmi without underflow");
    irq_cause_a: assert property (
        $rose(underflow_irq_o) |-> $past(action_sel_i[1])
        && $past(count_o) == 0) else $error("irq without underflow");
    rst_cause_a: assert property (
        $rose(chip_reset_o) |-> $past(action_sel_i) == 2'h0
        && $past(count_o) == 0) else $error("reset without underflow");
    // The chip reset request lasts exactly four cycles.
    rst_len_a: assert property (
        $rose(chip_reset_o) |-> chip_reset_o[*4] ##1 !chip_reset_o)
        else $error("reset pulse length wrong");
    // The NMI request is a single cycle pulse.
    nmi_pulse_a: assert property (
        nmi_o |=> !nmi_o) else $error("nmi longer than one cycle");
    // Automatic start runs the counter right after reset.
    auto_start_a: assert property (
        $fell(reset_i) && auto_start_i |=> running_o)
        else $error("no automatic start");
    // A wrong byte while running flags a refresh error.
    bad_byte_a: assert property (
        refresh_wr_i && running_o && refresh_data_i != 8'h00
        && refresh_data_i != 8'hFF |=> refresh_error_o)
        else $error("bad refresh not flagged");
endmodule

// [tb/iwdc_top_tb.sv]
// Self-checking bench for the watchdog counter top.
// Assumes the package and design files are compiled before it.
`define CHK(nm, ex, gt) begin n_tests++; if ((gt) !== (ex)) begin \
    error_cnt++; $display("[FAIL] %s exp %0h got %0h", nm, ex, gt); end end
module iwdc_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk_i = 1'b0;
    logic reset_i = 1'b1;
    logic osc_i = 1'b0;
    logic osc_en = 1'b0; // Oscillator stands still when low.
    logic [1:0] action_sel_i = 2'h2;
    logic auto_start_i = 1'b1;
    logic refresh_wr_i = 1'b0;
    logic [7:0] refresh_data_i = 8'h00;
    logic chip_reset_o, nmi_o, underflow_irq_o, refresh_error_o, running_o;
    logic [13:0] count_o;
    int error_cnt = 0;
    int n_tests = 0;
    iwdc_top dut (.sys_clk_i(sys_clk_i), .reset_i(reset_i),
        .low_speed_internal_osc_i(osc_i), .action_sel_i(action_sel_i),
        .auto_start_i(auto_start_i), .refresh_wr_i(refresh_wr_i),
        .refresh_data_i(refresh_data_i), .chip_reset_o(chip_reset_o),
        .nmi_o(nmi_o), .underflow_irq_o(underflow_irq_o),
        .refresh_error_o(refresh_error_o), .count_o(count_o),
        .running_o(running_o));
    initial
    begin
        forever #20 sys_clk_i = ~sys_clk_i;
    end
    // The slow oscillator toggles once per cycle, one tick per two cycles.
    always @(posedge sys_clk_i) osc_i <= #1 osc_en ? ~osc_i : osc_i;
    task automatic step(int n);
        repeat (n) @(posedge sys_clk_i);
        #1;
    endtask
    task automatic end_sim();
        $display("Checks %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    // Writes the key pair on two consecutive cycles, then lets an edge pass
    // with the strobe low so that a following write starts cleanly.
    task automatic refresh();
        refresh_wr_i = 1'b1;
        refresh_data_i = 8'h00;
        step(1);
        refresh_data_i = 8'hFF;
        step(1);
        refresh_wr_i = 1'b0;
        step(1);
    endtask
    task automatic bad(logic [7:0] b);
        refresh_wr_i = 1'b1;
        refresh_data_i = b;
        step(1);
        refresh_wr_i = 1'b0;
    endtask
    // Ticks lower the count, then the key pair restores it.
    task automatic t_count();
        osc_en = 1'b1;
        step(40);
        osc_en = 1'b0;
        step(4);
        // Forty toggles give twenty rising edges, each one step down.
        `CHK("dec", 14'h3FEB, count_o)
        refresh();
        `CHK("reload", 14'h3FFF, count_o)
        `CHK("run", 1'b1, running_o)
        $display("count test done");
    endtask
    // Wrong bytes, and a second key without the first, are flagged.
    task automatic t_error();
        bad(8'h5A);
        `CHK("err", 1'b1, refresh_error_o)
        step(1);
        bad(8'hFF);
        `CHK("err_ff", 1'b1, refresh_error_o)
        step(2);
        `CHK("restart", 1'b1, running_o)
        $display("error test done");
    endtask
    // A full countdown under each action code fires that action.
    task automatic t_under();
        logic hit;
        for (int k = 0; k < 3; k++)
        begin
            action_sel_i = 2'(k);
            // The last pass runs without auto start, so underflow stops it.
            auto_start_i = (k != 2);
            refresh();
            osc_en = 1'b1;
            hit = 1'b0;
            for (int i = 0; i < 34000 && hit !== 1'b1; i++)
            begin
                step(1);
                hit = k == 0 ? chip_reset_o : k == 1 ? nmi_o : underflow_irq_o;
            end
            osc_en = 1'b0;
            `CHK("action", 1'b1, hit)
            if (hit !== 1'b1)
                end_sim();
            `CHK("uf_run", k != 2, running_o)
            `CHK("uf_count", 14'h3FFF, count_o)
            step(8);
        end
        // Stopped by underflow, a wrong byte is flagged but restarts nothing.
        bad(8'h3C);
        `CHK("stop_err", 1'b1, refresh_error_o)
        step(1);
        `CHK("stop_hold", 1'b0, running_o)
        refresh();
        `CHK("stop_run", 1'b1, running_o)
        auto_start_i = 1'b1;
        $display("underflow test done");
    endtask
    // Reset is held for eight edges; auto start runs the counter at once.
    task automatic t_reset();
        step(8);
        reset_i = 1'b0;
        step(2);
        `CHK("rst_cnt", 14'h3FFF, count_o)
        `CHK("auto", 1'b1, running_o)
        $display("reset test done");
    endtask
    initial
    begin
        t_reset();
        t_count();
        t_error();
        t_under();
        end_sim();
    end
endmodule
bind iwdc_top iwdc_top_sva chk (.sys_clk_i(sys_clk_i), .reset_i(reset_i),
    .action_sel_i(action_sel_i), .auto_start_i(auto_start_i),
    .refresh_wr_i(refresh_wr_i), .refresh_data_i(refresh_data_i),
    .chip_reset_o(chip_reset_o), .nmi_o(nmi_o),
    .underflow_irq_o(underflow_irq_o), .refresh_error_o(refresh_error_o),
    .count_o(count_o), .running_o(running_o));
